// ===== lram_pkg.sv
/*
 * shared constants, location type and address decode for the local ram
 * access ports (operand-side and instruction-side on-chip rams).
 * assumes: one core clock, byte addresses of 32 bits, 32-bit word data.
 */
package lram_pkg;

   // -----------------------------------------------------------------
   // channels: two direct buses, internal cache/ram bus, interconnect
   // -----------------------------------------------------------------
   localparam int NCH = 4;
   localparam int CH_OPD = 0;       // direct operand bus
   localparam int CH_IFD = 1;       // direct instruction bus
   localparam int CH_ICB = 2;       // internal cache/ram bus
   localparam int CH_XB = 3;        // system interconnect, physical

   // response latency in clock cycles, counted from the taking edge
   localparam logic [2:0] LAT_DIRECT = 3'h1;
   localparam logic [2:0] LAT_ICB = 3'h4;
   localparam logic [2:0] LAT_XB = 3'h2;

   // -----------------------------------------------------------------
   // address windows
   // -----------------------------------------------------------------
   localparam logic [31:0] OPR_VBASE = 32'he500e000;
   localparam logic [31:0] OPR_PBASE = 32'h1400e000;
   localparam logic [31:0] OPR_BYTES = 32'h00004000;
   localparam logic [31:0] INS_VBASE = 32'he5200000;
   localparam logic [31:0] INS_PBASE = 32'h14200000;
   localparam logic [31:0] INS_BYTES = 32'h00002000;
   localparam int OPR_PAGE_BIT = 13;  // 8 kbyte pages
   localparam int INS_PAGE_BIT = 12;  // 4 kbyte pages
   localparam int IDX_W = 11;
   localparam int BANK_WORDS = 2048;
   localparam int NBANK = 4;

   typedef enum logic {
      RAM_OPR = 1'b0,
      RAM_INS = 1'b1
   } lram_ram_t;

   typedef struct packed {
      logic hit;
      lram_ram_t ram;
      logic page;
      logic [IDX_W-1:0] idx;
   } lram_loc_t;

   // -----------------------------------------------------------------
   // decode a byte address to ram, page and word within the page
   // -----------------------------------------------------------------
   function automatic lram_loc_t lram_map(input logic [31:0] a, input logic virt);
      lram_loc_t l;
      logic [31:0] ob;
      logic [31:0] ib;
      logic [31:0] off;
      l = '0;
      ob = virt ? OPR_VBASE : OPR_PBASE;
      ib = virt ? INS_VBASE : INS_PBASE;
      off = 32'h0;
      if (a >= ob && (a - ob) < OPR_BYTES) begin
         off = a - ob;
         l.hit = 1'b1;
         l.ram = RAM_OPR;
         l.page = off[OPR_PAGE_BIT];
         l.idx = off[12:2];
      end else if (a >= ib && (a - ib) < INS_BYTES) begin
         off = a - ib;
         l.hit = 1'b1;
         l.ram = RAM_INS;
         l.page = off[INS_PAGE_BIT];
         l.idx = {1'b0, off[11:2]};
      end
      return l;
   endfunction

   function automatic logic [2:0] ch_lat(input int ch);
      logic [2:0] r;
      r = LAT_DIRECT;
      if (ch == CH_ICB) begin
         r = LAT_ICB;
      end else if (ch == CH_XB) begin
         r = LAT_XB;
      end
      return r;
   endfunction

endpackage

// ===== lram_if.sv
/*
 * carrier between the local ram device end and the core/interconnect end.
 * assumes: both ends on clk_sys; each channel holds req until done.
 */
`timescale 1ns/10ps
interface lram_if;

   // -----------------------------------------------------------------
   // request side, one slot per channel
   // -----------------------------------------------------------------
   logic [lram_pkg::NCH-1:0] req;
   logic [lram_pkg::NCH-1:0] we;
   logic [31:0] addr [lram_pkg::NCH];
   logic [31:0] wdata [lram_pkg::NCH];
   logic [1:0] core [lram_pkg::NCH];
   logic [lram_pkg::NCH-1:0] cach;    // interconnect: cacheable
   logic [lram_pkg::NCH-1:0] fetch;   // interconnect: instruction fetch

   // -----------------------------------------------------------------
   // answer side
   // -----------------------------------------------------------------
   logic [lram_pkg::NCH-1:0] done;
   logic [lram_pkg::NCH-1:0] err;
   logic [lram_pkg::NCH-1:0] fill_oc;
   logic [lram_pkg::NCH-1:0] fill_ic;
   logic [31:0] rdata [lram_pkg::NCH];

   modport dev (
      input req, we, addr, wdata, core, cach, fetch,
      output done, err, fill_oc, fill_ic, rdata
   );

   modport host (
      output req, we, addr, wdata, core, cach, fetch,
      input done, err, fill_oc, fill_ic, rdata
   );

endinterface

// ===== lram_dev.sv
/*
 * device end: the two local rams of one core with their four access
 * paths, page arbitration, latency timing and sleep refusal.
 * assumes: the far end holds each request until its done pulse and
 * keeps software ordering (write-back, invalidate, barrier) itself.
 */
// How it works
// R1: operand ram by direct bus or interconnect
// R2: direct operand access done in one cycle
// R3: direct ports serve the owning core only
// R4: instruction ram operands via internal bus, interconnect
// R5: internal-bus operand access takes several cycles
// R6: fetch from operand ram: internal bus, interconnect
// R7: direct fetch single cycle, owning core only
// R8: cacheable interconnect reads fill matching cache
// R9: software writes back before dma reads
// R10: software invalidates icache before running changed code
// R11: write code, barrier, block invalidate, branch
// R12: never same address via both paths together; the host holds back only a late launch, two launched at one edge both go
// R13: sleep refuses interconnect, light sleep allows
// R14: page number holds physical local ram address
// R15: virtual window accesses are never cacheable
// R16: same physical address from every core
// R17: same-page clash: serve one, other next cycle
`timescale 1ns/10ps
module lram_dev #(
   parameter logic [1:0] OWN_CORE = 2'h0
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // power state of the owning core
   input wire logic sleep_mode,
   input wire logic light_sleep,
   // access channels
   lram_if.dev bus
);

   localparam int NCH = lram_pkg::NCH;

   // -----------------------------------------------------------------
   // storage: four banks, one per ram page
   // -----------------------------------------------------------------
   logic [31:0] mem [lram_pkg::NBANK][lram_pkg::BANK_WORDS];

   lram_pkg::lram_loc_t loc [NCH];
   logic [1:0] bank [NCH];
   logic [NCH-1:0] ok;
   logic [NCH-1:0] busy;
   logic [NCH-1:0] want;
   logic [NCH-1:0] block;
   logic [NCH-1:0] take;
   logic xb_refused;

   logic [2:0] cnt_q [NCH];
   logic [31:0] rdata_q [NCH];
   logic [NCH-1:0] done_q;
   logic [NCH-1:0] err_q;
   logic [NCH-1:0] foc_q;
   logic [NCH-1:0] fic_q;
   logic [NCH-1:0] stalled_q;
   logic [NCH-1:0] fin;
   logic [NCH-1:0] errh_d;
   logic [NCH-1:0] foch_d;
   logic [NCH-1:0] fich_d;
   logic [NCH-1:0] errh_q;
   logic [NCH-1:0] foch_q;
   logic [NCH-1:0] fich_q;

   // -----------------------------------------------------------------
   // path legality
   // -----------------------------------------------------------------
   // R13: full sleep shuts out interconnect masters
   assign xb_refused = sleep_mode & ~light_sleep;

   // decode every channel; only the interconnect uses physical addresses
   always_comb begin
      for (int i = 0; i < NCH; i++) begin
         loc[i] = lram_pkg::lram_map(bus.addr[i], i != lram_pkg::CH_XB);
         bank[i] = {loc[i].ram, loc[i].page};
         busy[i] = (cnt_q[i] != 3'h0) | done_q[i];
         want[i] = bus.req[i] & ~busy[i];
      end
   end

   // R3: direct and internal paths serve the owning core only; a foreign core gets done with err
   // R1: operand bus reaches only the operand ram
   // R7: instruction bus reaches only the instruction ram
   // R4: internal bus may reach either ram
   // R6: fetches from the operand ram go over the internal bus
   // R16: interconnect decode ignores the requesting core
   assign ok[lram_pkg::CH_OPD] = loc[lram_pkg::CH_OPD].hit
      & (loc[lram_pkg::CH_OPD].ram == lram_pkg::RAM_OPR)
      & (bus.core[lram_pkg::CH_OPD] == OWN_CORE);
   assign ok[lram_pkg::CH_IFD] = loc[lram_pkg::CH_IFD].hit
      & (loc[lram_pkg::CH_IFD].ram == lram_pkg::RAM_INS)
      & (bus.core[lram_pkg::CH_IFD] == OWN_CORE);
   assign ok[lram_pkg::CH_ICB] = loc[lram_pkg::CH_ICB].hit
      & (bus.core[lram_pkg::CH_ICB] == OWN_CORE);
   assign ok[lram_pkg::CH_XB] = loc[lram_pkg::CH_XB].hit & ~xb_refused;

   // -----------------------------------------------------------------
   // page arbitration
   // -----------------------------------------------------------------
   // R17: a loser of last cycle outranks fixed priority, so of two on a page it waits
   // one cycle, a third waits two; refused requests never touch a bank and never clash
   always_comb begin
      for (int i = 0; i < NCH; i++) begin
         block[i] = 1'b0;
         for (int j = 0; j < NCH; j++) begin
            if (j != i && want[j] && ok[j] && ok[i] && bank[j] == bank[i]
                && ((stalled_q[j] && !stalled_q[i])
                    || (stalled_q[j] == stalled_q[i] && j < i))) begin
               block[i] = 1'b1;
            end
         end
      end
   end

   assign take = want & ~block;

   // -----------------------------------------------------------------
   // channel timing and answers
   // -----------------------------------------------------------------
   // R2: a one-cycle path finishes at its own taking edge, so done shows
   // in the very next cycle; longer paths finish when the count reads 2
   // R5: internal bus loads a longer count
   always_comb begin
      for (int i = 0; i < NCH; i++) begin
         fin[i] = take[i] ? (lram_pkg::ch_lat(i) == 3'h1) : (cnt_q[i] == 3'h2);
      end
   end

   // answer attributes: fresh at the taking edge, held until done
   // R8: cacheable interconnect reads fill the cache of their kind
   // R15: anything through the virtual window reports uncached
   always_comb begin
      for (int i = 0; i < NCH; i++) begin
         errh_d[i] = take[i] ? ~ok[i] : errh_q[i];
         foch_d[i] = take[i] ? ((i == lram_pkg::CH_XB) & ok[i] & bus.cach[i]
            & ~bus.we[i] & ~bus.fetch[i]) : foch_q[i];
         fich_d[i] = take[i] ? ((i == lram_pkg::CH_XB) & ok[i] & bus.cach[i]
            & ~bus.we[i] & bus.fetch[i]) : fich_q[i];
      end
   end

   // latency count per channel; busy until it has run down
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         for (int i = 0; i < NCH; i++) begin
            cnt_q[i] <= 3'h0;
         end
         stalled_q <= '0;
      end else begin
         for (int i = 0; i < NCH; i++) begin
            if (take[i]) begin
               cnt_q[i] <= lram_pkg::ch_lat(i);
            end else if (cnt_q[i] != 3'h0) begin
               cnt_q[i] <= cnt_q[i] - 3'h1;
            end
         end
         stalled_q <= want & block;
      end
   end

   // answer pulses are flops of their own, so no gate sits on an output
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         done_q <= '0;
         err_q <= '0;
         foc_q <= '0;
         fic_q <= '0;
         errh_q <= '0;
         foch_q <= '0;
         fich_q <= '0;
      end else begin
         done_q <= fin;
         err_q <= fin & errh_d;
         foc_q <= fin & foch_d;
         fic_q <= fin & fich_d;
         errh_q <= errh_d;
         foch_q <= foch_d;
         fich_q <= fich_d;
      end
   end

   // ram read and write happen at the taking edge; no reset on storage.
   // no coherency with any cache is attempted here
   always_ff @(posedge clk_sys) begin
      for (int i = 0; i < NCH; i++) begin
         if (take[i] && ok[i]) begin
            rdata_q[i] <= mem[bank[i]][loc[i].idx];
            if (bus.we[i]) begin
               mem[bank[i]][loc[i].idx] <= bus.wdata[i];
            end
         end else if (rst) begin
            rdata_q[i] <= 32'h0;
         end
      end
   end

   // -----------------------------------------------------------------
   // outputs, all from flip-flops
   // -----------------------------------------------------------------
   assign bus.done = done_q;
   assign bus.err = err_q;
   assign bus.fill_oc = foc_q;
   assign bus.fill_ic = fic_q;
   assign bus.rdata = rdata_q;

endmodule

// ===== lram_host.sv
/*
 * far end: the core and interconnect side that launches accesses into
 * the local rams, one held request per channel.
 * assumes: user holds u_req until u_ack; software keeps cache ordering.
 */
`timescale 1ns/10ps
module lram_host #(
   parameter logic [1:0] CORE_ID = 2'h0
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // user requests, one slot per channel
   input wire logic [lram_pkg::NCH-1:0] u_req,
   input wire logic [lram_pkg::NCH-1:0] u_we,
   input wire logic [31:0] u_addr [lram_pkg::NCH],
   input wire logic [31:0] u_wdata [lram_pkg::NCH],
   input wire logic [lram_pkg::NCH-1:0] u_cach,
   input wire logic [lram_pkg::NCH-1:0] u_fetch,
   // user answers
   output logic [lram_pkg::NCH-1:0] u_ack,
   output logic [lram_pkg::NCH-1:0] u_done,
   output logic [lram_pkg::NCH-1:0] u_err,
   output logic [lram_pkg::NCH-1:0] u_fill_oc,
   output logic [lram_pkg::NCH-1:0] u_fill_ic,
   output logic [31:0] u_rdata [lram_pkg::NCH],
   // ram channels
   lram_if.host bus
);

   localparam int NCH = lram_pkg::NCH;

   logic [NCH-1:0] pend_q;
   logic [NCH-1:0] we_q;
   logic [NCH-1:0] cach_q;
   logic [NCH-1:0] fetch_q;
   logic [31:0] addr_q [NCH];
   logic [31:0] wdata_q [NCH];
   logic [NCH-1:0] clash;
   logic [NCH-1:0] take;
   lram_pkg::lram_loc_t nloc [NCH];
   lram_pkg::lram_loc_t ploc [NCH];

   // -----------------------------------------------------------------
   // launch control
   // -----------------------------------------------------------------
   // R12: a word pending on the interconnect is not launched over a direct
   // or internal path, and the other way round; the late one waits, but launches at one edge both go
   // R14: interconnect slot decodes physical addresses only
   always_comb begin
      for (int i = 0; i < NCH; i++) begin
         nloc[i] = lram_pkg::lram_map(u_addr[i], i != lram_pkg::CH_XB);
         ploc[i] = lram_pkg::lram_map(addr_q[i], i != lram_pkg::CH_XB);
      end
      for (int i = 0; i < NCH; i++) begin
         clash[i] = 1'b0;
         for (int j = 0; j < NCH; j++) begin
            if (pend_q[j] && ((i == lram_pkg::CH_XB) != (j == lram_pkg::CH_XB))
                && nloc[i].hit && ploc[j].hit
                && nloc[i].ram == ploc[j].ram && nloc[i].page == ploc[j].page
                && nloc[i].idx == ploc[j].idx) begin
               clash[i] = 1'b1;
            end
         end
      end
   end

   assign take = u_req & ~pend_q & ~clash;

   // R9: R10: R11: user order kept, nothing cached
   // request slot held until the device answers
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pend_q <= '0;
         we_q <= '0;
         cach_q <= '0;
         fetch_q <= '0;
         for (int i = 0; i < NCH; i++) begin
            addr_q[i] <= 32'h0;
            wdata_q[i] <= 32'h0;
         end
      end else begin
         for (int i = 0; i < NCH; i++) begin
            if (take[i]) begin
               pend_q[i] <= 1'b1;
               we_q[i] <= u_we[i];
               cach_q[i] <= u_cach[i];
               fetch_q[i] <= u_fetch[i];
               addr_q[i] <= u_addr[i];
               wdata_q[i] <= u_wdata[i];
            end else if (bus.done[i]) begin
               pend_q[i] <= 1'b0;
            end
         end
      end
   end

   // answers registered once more toward the user
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         u_ack <= '0;
         u_done <= '0;
         u_err <= '0;
         u_fill_oc <= '0;
         u_fill_ic <= '0;
         for (int i = 0; i < NCH; i++) begin
            u_rdata[i] <= 32'h0;
         end
      end else begin
         u_ack <= take;
         u_done <= bus.done;
         u_err <= bus.err;
         u_fill_oc <= bus.fill_oc;
         u_fill_ic <= bus.fill_ic;
         for (int i = 0; i < NCH; i++) begin
            u_rdata[i] <= bus.rdata[i];
         end
      end
   end

   // -----------------------------------------------------------------
   // channel drive, all from flip-flops but the constant core id
   // -----------------------------------------------------------------
   assign bus.req = pend_q;
   assign bus.we = we_q;
   assign bus.addr = addr_q;
   assign bus.wdata = wdata_q;
   assign bus.cach = cach_q;
   assign bus.fetch = fetch_q;
   assign bus.core = '{default: CORE_ID};

endmodule

// ===== lram_assertions.sv
/*
 * checker on the carrier: latency, pulse width, fill flags, sleep refusal.
 * assumes: one clock, rst synchronous high, wired to the carrier by the bench.
 */
`timescale 1ns/10ps
module lram_assertions (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // power state of the owning core
   input wire logic sleep_mode,
   input wire logic light_sleep,
   // carrier signals, one bit per channel
   input wire logic [3:0] req,
   input wire logic [3:0] we,
   input wire logic [3:0] cach,
   input wire logic [3:0] fetch,
   input wire logic [3:0] done,
   input wire logic [3:0] err,
   input wire logic [3:0] fill_oc,
   input wire logic [3:0] fill_ic
);
   // ------------------------------------------------------------
   // properties, single clock domain
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   a_done_one_pulse: assert property ((done & $past(done)) == 4'h0)
      else $error("done pulse longer than one cycle");
   // a lone request has nothing to clash with, so no stall
   a_opd_one_cycle: assert property ($rose(req[0]) && req[3:1] == 3'h0 |=> done[0])
      else $error("direct operand access not done in one cycle");
   a_opd_stall_bound: assert property ($rose(req[0]) |-> ##[1:3] done[0])
      else $error("direct operand access stalled too long");
   a_ifd_one_cycle: assert property ($rose(req[1]) && (req & 4'hd) == 4'h0 |=> done[1])
      else $error("direct fetch not done in one cycle");
   a_icb_several: assert property ($rose(req[2]) && (req & 4'hb) == 4'h0 |=>
      !done[2] [*3] ##1 done[2])
      else $error("internal bus latency wrong");
   a_xb_latency: assert property ($rose(req[3]) && (req & 4'h7) == 4'h0 |=>
      !done[3] ##1 done[3])
      else $error("interconnect latency wrong");
   a_fill_oc_cause: assert property (done[3] |->
      fill_oc[3] == (cach[3] && !fetch[3] && !we[3] && !err[3]))
      else $error("operand cache fill flag wrong");
   a_fill_ic_cause: assert property (done[3] |->
      fill_ic[3] == (cach[3] && fetch[3] && !we[3] && !err[3]))
      else $error("instruction cache fill flag wrong");
   a_window_uncached: assert property ((fill_oc[2:0] | fill_ic[2:0]) == 3'h0)
      else $error("virtual window access marked cacheable");
   a_sleep_refuses: assert property (done[3] && $past(sleep_mode, 2) &&
      !$past(light_sleep, 2) |-> err[3])
      else $error("interconnect served during sleep");
endmodule

// ===== lram_local_ram_access_ports_tb.sv
/*
 * self-checking bench with two host/device pairs; the second host has a
 * foreign core id, so its direct requests must all be refused.
 * assumes: package, carrier, both ends and the checker compiled first.
 */
`timescale 1ns/10ps
module lram_local_ram_access_ports_tb;
   // ------------------------------------------------------------
   // stimulus, answers and the two pairs
   // ------------------------------------------------------------
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic sleep_mode = 1'b0;
   logic light_sleep = 1'b0;
   logic [3:0] u_req = 4'h0;
   logic [3:0] u_we = 4'h0;
   logic [3:0] u_cach = 4'h0;
   logic [3:0] u_fetch = 4'h0;
   logic [31:0] u_addr [4] = '{default: 32'h0};
   logic [31:0] u_wdata [4] = '{default: 32'h0};
   logic [31:0] u_rdata [4];
   logic [3:0] u_ack, u_done, u_err, u_foc, u_fic, b_done, b_err;
   logic [3:0] b_seen = 4'h0;
   int mismatches = 0;
   int num_checks = 0;
   lram_if bus_a ();
   lram_if bus_b ();

   lram_host u_lram_host (.clk_sys(clk_sys), .rst(rst), .u_req(u_req), .u_we(u_we),
      .u_addr(u_addr), .u_wdata(u_wdata), .u_cach(u_cach), .u_fetch(u_fetch),
      .u_ack(u_ack), .u_done(u_done), .u_err(u_err), .u_fill_oc(u_foc),
      .u_fill_ic(u_fic), .u_rdata(u_rdata), .bus(bus_a));
   lram_dev u_lram_dev (.clk_sys(clk_sys), .rst(rst), .sleep_mode(sleep_mode),
      .light_sleep(light_sleep), .bus(bus_a));
   // same stimulus from a foreign core, kept only for its refusal flags
   lram_host #(.CORE_ID(2'h1)) u_lram_host_b (.clk_sys(clk_sys), .rst(rst), .u_req(u_req),
      .u_we(u_we), .u_addr(u_addr), .u_wdata(u_wdata), .u_cach(u_cach), .u_fetch(u_fetch),
      .u_ack(), .u_done(b_done), .u_err(b_err), .u_fill_oc(), .u_fill_ic(), .u_rdata(),
      .bus(bus_b));
   lram_dev #(.OWN_CORE(2'h0)) u_lram_dev_b (.clk_sys(clk_sys), .rst(rst),
      .sleep_mode(sleep_mode), .light_sleep(light_sleep), .bus(bus_b));
   lram_assertions u_lram_assertions (.clk_sys(clk_sys), .rst(rst), .sleep_mode(sleep_mode),
      .light_sleep(light_sleep), .req(bus_a.req), .we(bus_a.we), .cach(bus_a.cach),
      .fetch(bus_a.fetch), .done(bus_a.done), .err(bus_a.err), .fill_oc(bus_a.fill_oc),
      .fill_ic(bus_a.fill_ic));

   // core clock, 25 ns
   initial begin
      forever #12.5 clk_sys = ~clk_sys;
   end

   // last refusal flag per channel of the foreign pair
   always @(posedge clk_sys) begin
      b_seen <= (b_seen & ~b_done) | (b_err & b_done);
   end

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] addr_of(input int ch, input int isel, input int idx);
      logic [31:0] b;
      if (ch == lram_pkg::CH_XB) begin
         b = (isel != 0) ? lram_pkg::INS_PBASE : lram_pkg::OPR_PBASE;
      end else begin
         b = (isel != 0) ? lram_pkg::INS_VBASE : lram_pkg::OPR_VBASE;
      end
      return b + 32'(idx * 4);
   endfunction

   // ack to done at the user side: one extra hop plus the path latency
   function automatic int lat_of(input int ch);
      logic [2:0] l;
      l = (ch == lram_pkg::CH_ICB) ? lram_pkg::LAT_ICB :
         (ch == lram_pkg::CH_XB) ? lram_pkg::LAT_XB : lram_pkg::LAT_DIRECT;
      return 1 + int'(l);
   endfunction

   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // one step of a bounded wait; running out ends the run
   task automatic tick(inout int k);
      @(posedge clk_sys);
      #1;
      k++;
      if (k > 40) begin
         mismatches++;
         results();
      end
   endtask

   // one held request: raise, drop on ack, collect at done
   task automatic xfer(input int ch, input logic w, input logic [31:0] a,
      input logic [31:0] d, input logic c, input logic f, output logic [31:0] rd,
      output logic [2:0] fl, output int n);
      int k;
      k = 0;
      @(posedge clk_sys);
      u_req[ch] <= 1'b1;
      u_we[ch] <= w;
      u_addr[ch] <= a;
      u_wdata[ch] <= d;
      u_cach[ch] <= c;
      u_fetch[ch] <= f;
      #1;
      while (u_ack[ch] !== 1'b1) tick(k);
      @(posedge clk_sys);
      u_req[ch] <= 1'b0;
      #1;
      n = 1;
      while (u_done[ch] !== 1'b1) tick(n);
      rd = u_rdata[ch];
      fl = {u_err[ch], u_foc[ch], u_fic[ch]};
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      logic [31:0] rd, rd2, d, d2, ba;
      logic [2:0] fl, fl2;
      logic c, f;
      int n, n2, idx, wc, rc, isel;
      int wr_tab [2][3] = '{'{0, 2, 3}, '{2, 3, 3}};
      int rd_tab [2][3] = '{'{0, 2, 3}, '{1, 2, 3}};
      void'($urandom(32'h8dc2e7e8));
      repeat (5) @(posedge clk_sys);
      #1;
      check({24'h0, u_ack, u_done}, 32'h0);
      @(posedge clk_sys);
      rst <= 1'b0;
      // random word written on one path, read back on a path drawn at random, possibly the same
      for (int k = 0; k < 24; k++) begin
         isel = $urandom % 2;
         idx = $urandom % int'(((isel != 0) ? lram_pkg::INS_BYTES : lram_pkg::OPR_BYTES) / 4);
         wc = wr_tab[isel][$urandom % 3];
         rc = rd_tab[isel][$urandom % 3];
         d = $urandom;
         c = 1'($urandom);
         f = 1'($urandom);
         xfer(wc, 1'b1, addr_of(wc, isel, idx), d, c, f, rd, fl, n);
         check(32'(n), 32'(lat_of(wc)));
         check({29'h0, fl}, 32'h0);
         xfer(rc, 1'b0, addr_of(rc, isel, idx), 32'h0, c, f, rd, fl, n);
         check(rd, d);
         check(32'(n), 32'(lat_of(rc)));
         check({29'h0, fl}, {30'h0, rc == 3 && c && !f, rc == 3 && c && f});
      end
      $display("test random paths done");
      // wrong ram or window per path; foreign core refused on direct paths
      for (int ch = 0; ch < 4; ch++) begin
         ba = (ch == 0) ? lram_pkg::INS_VBASE : (ch == 2) ? 32'h0 : lram_pkg::OPR_VBASE;
         xfer(ch, 1'b0, ba, 32'h0, 1'b0, 1'b0, rd, fl, n);
         check({31'h0, fl[2]}, 32'h1);
         check(32'(n), 32'(lat_of(ch)));
         xfer(ch, 1'b0, addr_of(ch, ch == 1, 9), 32'h0, 1'b0, 1'b0, rd, fl, n);
         @(posedge clk_sys);
         #1;
         check({31'h0, fl[2]}, 32'h0);
         check({31'h0, b_seen[ch]}, {31'h0, ch != 3});
      end
      $display("test refusals done");
      // sleep shuts the interconnect out, light sleep does not
      for (int s = 0; s < 2; s++) begin
         @(posedge clk_sys);
         sleep_mode <= 1'b1;
         light_sleep <= (s == 1);
         xfer(3, 1'b0, addr_of(3, 0, 3), 32'h0, 1'b0, 1'b0, rd, fl, n);
         check({31'h0, fl[2]}, {31'h0, s == 0});
         xfer(0, 1'b0, addr_of(0, 0, 3), 32'h0, 1'b0, 1'b0, rd, fl, n);
         check({31'h0, fl[2]}, 32'h0);
      end
      @(posedge clk_sys);
      sleep_mode <= 1'b0;
      light_sleep <= 1'b0;
      $display("test sleep done");
      // same page from two paths at one edge: one waits a cycle, both intact
      for (int p = 0; p < 2; p++) begin
         idx = $urandom % 1000;
         d = $urandom;
         d2 = $urandom;
         xfer(3, 1'b1, addr_of(3, p, idx), d, 1'b0, 1'b0, rd, fl, n);
         xfer(3, 1'b1, addr_of(3, p, idx + 1), d2, 1'b0, 1'b0, rd, fl, n);
         fork
            xfer(p, 1'b0, addr_of(p, p, idx), 32'h0, 1'b0, 1'b0, rd, fl, n);
            xfer(3 - p, 1'b0, addr_of(3 - p, p, idx + 1), 32'h0, 1'b0, 1'b0, rd2, fl2, n2);
         join
         check(rd, d);
         check(rd2, d2);
         check(32'(n + n2 - lat_of(p) - lat_of(3 - p)), 32'h1);
      end
      $display("test page clash done");
      results();
   end
endmodule
